// ---- rtl/dihr_defines.svh ----
// Timing constants and reset levels for the dual input hold reset generator
`ifndef DIHR_DEFINES_SVH
`define DIHR_DEFINES_SVH

// System clock rate in kHz (25 MHz)
`define DIHR_CLK_KHZ 25000

// Factory hold timeout options in milliseconds, nominal values
`define DIHR_HOLD_MS_0 500
`define DIHR_HOLD_MS_1 1000
`define DIHR_HOLD_MS_2 1500
`define DIHR_HOLD_MS_3 2000
`define DIHR_HOLD_MS_4 2500
`define DIHR_HOLD_MS_5 3000
`define DIHR_HOLD_MS_6 4000
`define DIHR_HOLD_MS_7 5000

// Reset pulse width options in microseconds, short and long variant
`define DIHR_PULSE_SHORT_US 2200
`define DIHR_PULSE_LONG_US 70000

// Accelerated test mode timing in microseconds
`define DIHR_TEST_DELAY_US 250
`define DIHR_TEST_WINDOW_US 35

// Number of test clock pulses that confirm test mode entry
`define DIHR_TEST_PULSES 8

// Idle level of both manual inputs, used as synchroniser reset value
`define DIHR_PIN_IDLE 1'b1

`endif

// ---- rtl/dihr_pkg.sv ----
// Types and helper functions shared by the hold reset generator files
`include "dihr_defines.svh"

package dihr_pkg;

   // Levels of the two manual inputs travelling together
   typedef struct packed {
      logic a;
      logic b;
   } dihr_pins_type;

   // Main sequencer states, one-hot
   typedef enum logic [5:0] {
      DIHR_IDLE  = 6'h01,
      DIHR_HOLD  = 6'h02,
      DIHR_PULSE = 6'h04,
      DIHR_LATCH = 6'h08,
      DIHR_TWAIT = 6'h10,
      DIHR_SPARE = 6'h20
   } dihr_state_type;

   // Nominal hold timeout in ms for a factory option index
   function automatic int unsigned dihr_hold_ms(input int unsigned sel);
      case (sel)
         0: dihr_hold_ms = `DIHR_HOLD_MS_0;
         1: dihr_hold_ms = `DIHR_HOLD_MS_1;
         2: dihr_hold_ms = `DIHR_HOLD_MS_2;
         3: dihr_hold_ms = `DIHR_HOLD_MS_3;
         4: dihr_hold_ms = `DIHR_HOLD_MS_4;
         5: dihr_hold_ms = `DIHR_HOLD_MS_5;
         6: dihr_hold_ms = `DIHR_HOLD_MS_6;
         default: dihr_hold_ms = `DIHR_HOLD_MS_7;
      endcase
   endfunction : dihr_hold_ms

   // Microseconds to clock cycles, rounded up, at least one cycle
   function automatic int unsigned dihr_us_to_cyc_up(input int unsigned us);
      int unsigned cyc;
      cyc = (us * `DIHR_CLK_KHZ + 999) / 1000;
      dihr_us_to_cyc_up = (cyc == 0) ? 1 : cyc;
   endfunction : dihr_us_to_cyc_up

endpackage : dihr_pkg

// ---- rtl/dihr_sync.sv ----
// Three-stage synchroniser with agreement filter for the manual inputs
`timescale 1ns/10ps
`include "dihr_defines.svh"

module dihr_sync
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire dihr_pkg::dihr_pins_type pins_raw,
   output dihr_pkg::dihr_pins_type pins_clean
);

   // Synchroniser chain stages
   dihr_pkg::dihr_pins_type stage1;
   dihr_pkg::dihr_pins_type stage2;
   dihr_pkg::dihr_pins_type stage3;
   // Next filtered level
   dihr_pkg::dihr_pins_type next_pins_clean;

   // Filtered level moves only when stages two and three agree
   always_comb
   begin
      next_pins_clean = pins_clean;
      if (stage2.a == stage3.a)
      begin
         next_pins_clean.a = stage3.a;
      end
      if (stage2.b == stage3.b)
      begin
         next_pins_clean.b = stage3.b;
      end
   end

   // Chain and filtered level; idle high after reset
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         stage1 <= {`DIHR_PIN_IDLE, `DIHR_PIN_IDLE};
         stage2 <= {`DIHR_PIN_IDLE, `DIHR_PIN_IDLE};
         stage3 <= {`DIHR_PIN_IDLE, `DIHR_PIN_IDLE};
         pins_clean <= {`DIHR_PIN_IDLE, `DIHR_PIN_IDLE};
      end
      else
      begin
         stage1 <= pins_raw;
         stage2 <= stage1;
         stage3 <= stage2;
         pins_clean <= next_pins_clean;
      end
   end

endmodule : dihr_sync

// ---- rtl/dihr_top.sv ----
// Dual input hold reset generator with accelerated test mode
`timescale 1ns/10ps
`include "dihr_defines.svh"

module dihr_top
#(
   // Factory hold timeout option, 0 to 7
   parameter int unsigned HOLD_SEL = 0,
   // Long pulse variant when 1, short variant when 0
   parameter int unsigned LONG_PULSE = 0,
   // Hold timeout in clock cycles
   parameter int unsigned HOLD_TIMEOUT_CYC =
      dihr_pkg::dihr_hold_ms(HOLD_SEL) * `DIHR_CLK_KHZ,
   // Reset pulse width in clock cycles
   parameter int unsigned PULSE_WIDTH_CYC = dihr_pkg::dihr_us_to_cyc_up(
      (LONG_PULSE != 0) ? `DIHR_PULSE_LONG_US : `DIHR_PULSE_SHORT_US),
   // Test mode delay in clock cycles
   parameter int unsigned TEST_DELAY_CYC =
      dihr_pkg::dihr_us_to_cyc_up(`DIHR_TEST_DELAY_US)
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic manual_input_a_n,
   input wire logic manual_input_b_n,
   output logic reset_line_out,
   output logic reset_line_oe,
   output logic accelerated_timer_test_mode
);

   // Entry window is a longest time: rounded down
   localparam int unsigned TEST_WINDOW_CYC =
      (`DIHR_TEST_WINDOW_US * `DIHR_CLK_KHZ) / 1000;
   // Required count of test clock pulses
   localparam logic [3:0] TEST_PULSES = 4'(`DIHR_TEST_PULSES);
   // Last count values of each timed phase
   localparam logic [31:0] HOLD_LAST = 32'(HOLD_TIMEOUT_CYC - 1);
   localparam logic [31:0] PULSE_LAST = 32'(PULSE_WIDTH_CYC - 1);
   localparam logic [31:0] TDELAY_LAST = 32'(TEST_DELAY_CYC - 1);
   localparam logic [15:0] WINDOW_LAST = 16'(TEST_WINDOW_CYC - 1);

   // Raw pin levels and their clean synchronised copy
   dihr_pkg::dihr_pins_type pins_raw;
   dihr_pkg::dihr_pins_type pins;
   // Previous clean levels for edge detection
   dihr_pkg::dihr_pins_type pins_prev;

   // Main sequencer state and its phase counter
   dihr_pkg::dihr_state_type state;
   dihr_pkg::dihr_state_type next_state;
   logic [31:0] cnt;
   logic [31:0] next_cnt;

   // Test entry detector state
   logic win_run;
   logic next_win_run;
   logic [15:0] win_cnt;
   logic [15:0] next_win_cnt;
   logic [3:0] edge_cnt;
   logic [3:0] next_edge_cnt;
   logic test_hit;
   logic next_test_hit;

   // Registered outputs
   logic next_reset_line_oe;
   logic next_test_mode;

   // Decoded conditions on clean levels
   logic both_low;
   logic both_high;
   logic fall_a;
   logic fall_b;
   logic rise_b;

   // Pins enter as active-low levels; b has its pull-up outside
   assign pins_raw = '{a: manual_input_a_n, b: manual_input_b_n};

   // Synchronise both inputs before any use
   dihr_sync u_sync
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .pins_raw(pins_raw),
      .pins_clean(pins)
   );

   // Level and edge decode of the clean inputs
   always_comb
   begin
      both_low = !pins.a && !pins.b;
      both_high = pins.a && pins.b;
      fall_a = pins_prev.a && !pins.a;
      fall_b = pins_prev.b && !pins.b;
      rise_b = !pins_prev.b && pins.b;
   end

   // Previous levels start at idle high, so reset gives no edge
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pins_prev <= {`DIHR_PIN_IDLE, `DIHR_PIN_IDLE};
      end
      else
      begin
         pins_prev <= pins;
      end
   end

   // Test entry detector: counts b pulses while a is low
   always_comb
   begin
      next_win_run = win_run;
      next_win_cnt = win_cnt;
      next_edge_cnt = edge_cnt;
      next_test_hit = 1'b0;
      if (pins.a || state == dihr_pkg::DIHR_TWAIT || state == dihr_pkg::DIHR_PULSE)
      begin
         // Input a high, test delay running or pulse active: detector idle
         next_win_run = 1'b0;
         next_win_cnt = '0;
         next_edge_cnt = '0;
      end
      else if (!win_run)
      begin
         // First b fall after a went low opens the window
         if (fall_b)
         begin
            next_win_run = 1'b1;
            next_win_cnt = '0;
            next_edge_cnt = '0;
         end
      end
      else if (rise_b && edge_cnt == TEST_PULSES - 4'h1)
      begin
         // Eighth rise inside the window confirms test mode
         next_test_hit = 1'b1;
         next_win_run = 1'b0;
         next_edge_cnt = '0;
      end
      else if (win_cnt == WINDOW_LAST)
      begin
         // Window ran out: stay in normal operation
         next_win_run = 1'b0;
         next_edge_cnt = '0;
      end
      else
      begin
         // Window running: count cycles and b rises
         next_win_cnt = win_cnt + 16'h0001;
         if (rise_b)
         begin
            next_edge_cnt = edge_cnt + 4'h1;
         end
      end
   end

   // Test entry detector registers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         win_run <= 1'b0;
         win_cnt <= '0;
         edge_cnt <= '0;
         test_hit <= 1'b0;
      end
      else
      begin
         win_run <= next_win_run;
         win_cnt <= next_win_cnt;
         edge_cnt <= next_edge_cnt;
         test_hit <= next_test_hit;
      end
   end

   // Main sequencer: hold count, pulse, latch and test delay
   always_comb
   begin
      next_state = state;
      next_cnt = cnt + 32'h0000_0001;
      case (state)
         dihr_pkg::DIHR_IDLE:
         begin
            next_cnt = '0;
            if (test_hit)
            begin
               // Test confirmed: begin the fixed delay
               next_state = dihr_pkg::DIHR_TWAIT;
            end
            else if (both_low)
            begin
               // Last input to go low starts the count
               next_state = dihr_pkg::DIHR_HOLD;
            end
         end
         dihr_pkg::DIHR_HOLD:
         begin
            if (test_hit)
            begin
               next_state = dihr_pkg::DIHR_TWAIT;
               next_cnt = '0;
            end
            else if (!both_low)
            begin
               // Early release clears the count
               next_state = dihr_pkg::DIHR_IDLE;
               next_cnt = '0;
            end
            else if (fall_a || fall_b)
            begin
               // A fresh falling edge restarts the count
               next_cnt = '0;
            end
            else if (cnt == HOLD_LAST)
            begin
               // Factory timeout reached
               next_state = dihr_pkg::DIHR_PULSE;
               next_cnt = '0;
            end
         end
         dihr_pkg::DIHR_PULSE:
         begin
            if (cnt == PULSE_LAST)
            begin
               // Pulse done; both low means wait for a release
               next_state = both_low ? dihr_pkg::DIHR_LATCH : dihr_pkg::DIHR_IDLE;
               next_cnt = '0;
            end
         end
         dihr_pkg::DIHR_LATCH:
         begin
            next_cnt = '0;
            if (test_hit)
            begin
               next_state = dihr_pkg::DIHR_TWAIT;
            end
            else if (!both_low)
            begin
               // A release re-arms the hold timer
               next_state = dihr_pkg::DIHR_IDLE;
            end
         end
         dihr_pkg::DIHR_TWAIT:
         begin
            if (both_high)
            begin
               // Both inputs high leave test mode at once
               next_state = dihr_pkg::DIHR_IDLE;
               next_cnt = '0;
            end
            else if (cnt == TDELAY_LAST)
            begin
               // Fixed test delay ends with a normal pulse
               next_state = dihr_pkg::DIHR_PULSE;
               next_cnt = '0;
            end
         end
         default:
         begin
            next_state = dihr_pkg::DIHR_IDLE;
            next_cnt = '0;
         end
      endcase
      // Output pin pulled low only during a pulse
      next_reset_line_oe = (next_state == dihr_pkg::DIHR_PULSE);
      // Test mode flag drops once the test pulse starts
      next_test_mode = (next_state == dihr_pkg::DIHR_TWAIT);
   end

   // Main sequencer registers; idle and released after reset
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state <= dihr_pkg::DIHR_IDLE;
         cnt <= '0;
         reset_line_oe <= 1'b0;
         reset_line_out <= 1'b0;
         accelerated_timer_test_mode <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         reset_line_oe <= next_reset_line_oe;
         // Open drain: the driven level is always low
         reset_line_out <= 1'b0;
         accelerated_timer_test_mode <= next_test_mode;
      end
   end

endmodule : dihr_top

// ---- bench/dihr_top_monitor.sv ----
// Port checker for the hold reset generator
`timescale 1ns/10ps
module dihr_top_monitor
#(
   parameter int unsigned HOLD_TIMEOUT_CYC = 200,
   parameter int unsigned PULSE_WIDTH_CYC = 50,
   parameter int unsigned TEST_DELAY_CYC = 100
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic manual_input_a_n,
   input wire logic manual_input_b_n,
   input wire logic reset_line_out,
   input wire logic reset_line_oe,
   input wire logic accelerated_timer_test_mode
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // Run lengths: pulse, both low, both high, test wait
   int unsigned oe_cnt, low_cnt, hi_cnt, tm_cnt, b_rises;
   // Previous level of input b
   logic b_q;
   // Counters that follow pins and outputs
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         oe_cnt <= 0;
         low_cnt <= 0;
         hi_cnt <= 0;
         tm_cnt <= 0;
         b_rises <= 0;
         b_q <= 1'b1;
      end
      else
      begin
         oe_cnt <= reset_line_oe ? oe_cnt + 1 : 0;
         low_cnt <= (!manual_input_a_n && !manual_input_b_n) ? low_cnt + 1 : 0;
         hi_cnt <= (manual_input_a_n && manual_input_b_n) ? hi_cnt + 1 : 0;
         tm_cnt <= accelerated_timer_test_mode ? tm_cnt + 1 : 0;
         b_q <= manual_input_b_n;
         b_rises <= manual_input_a_n ? 0 : b_rises + ((manual_input_b_n && !b_q) ? 1 : 0);
      end
   end
   // Start and end of a pulse
   sequence s_rise;
      $rose(reset_line_oe);
   endsequence
   sequence s_fall;
      $fell(reset_line_oe);
   endsequence
   // Driven level of the open-drain output
   property p_out_low;
      reset_line_out == 1'b0;
   endproperty
   property p_width;
      s_fall |-> oe_cnt == PULSE_WIDTH_CYC;
   endproperty
   // Normal pulse starts a fixed time after both pins went low
   property p_hold;
      s_rise ##0 !$past(accelerated_timer_test_mode) |->
         low_cnt inside {[HOLD_TIMEOUT_CYC + 3:HOLD_TIMEOUT_CYC + 8]};
   endproperty
   property p_tdelay;
      s_rise ##0 $past(accelerated_timer_test_mode) |->
         tm_cnt inside {[TEST_DELAY_CYC - 1:TEST_DELAY_CYC + 1]};
   endproperty
   // Test mode flag versus pulses, aborts and entry; no pulse just after reset
   property p_texit;
      reset_line_oe |-> !accelerated_timer_test_mode;
   endproperty
   property p_tabort;
      hi_cnt >= 8 |-> !accelerated_timer_test_mode;
   endproperty
   property p_poweron;
      $past(rst) |-> !reset_line_oe [*8];
   endproperty
   property p_tentry;
      $rose(accelerated_timer_test_mode) |-> b_rises >= 8;
   endproperty
   a_out_low: assert property (p_out_low)
      else $error("reset output value not low");
   a_width: assert property (p_width)
      else $error("reset pulse width wrong");
   a_hold: assert property (p_hold)
      else $error("pulse not after hold time");
   a_tdelay: assert property (p_tdelay)
      else $error("test delay wrong");
   a_texit: assert property (p_texit)
      else $error("test mode during pulse");
   a_tabort: assert property (p_tabort)
      else $error("test mode kept with both high");
   a_poweron: assert property (p_poweron)
      else $error("pulse right after reset");
   a_tentry: assert property (p_tentry)
      else $error("test mode without eight pulses");
endmodule : dihr_top_monitor

bind dihr_top dihr_top_monitor #(
   .HOLD_TIMEOUT_CYC(HOLD_TIMEOUT_CYC),
   .PULSE_WIDTH_CYC(PULSE_WIDTH_CYC),
   .TEST_DELAY_CYC(TEST_DELAY_CYC)
) u_mon (
   .sys_clk(sys_clk),
   .rst(rst),
   .manual_input_a_n(manual_input_a_n),
   .manual_input_b_n(manual_input_b_n),
   .reset_line_out(reset_line_out),
   .reset_line_oe(reset_line_oe),
   .accelerated_timer_test_mode(accelerated_timer_test_mode)
);

// ---- bench/dihr_switch_model.sv ----
// Two switches and a pulled-up processor reset line
`timescale 1ns/10ps
module dihr_switch_model
(
   input wire logic press_a,
   input wire logic press_b,
   input wire logic reset_line_out,
   input wire logic reset_line_oe,
   output dihr_pkg::dihr_pins_type pins,
   output logic reset_wire
);
   // Switch a always gives a defined level; b floats high through its pull-up
   assign pins = '{a: !press_a, b: !press_b};
   // Pull-up wins unless the output sinks
   assign reset_wire = reset_line_oe ? reset_line_out : 1'b1;
endmodule : dihr_switch_model

// ---- bench/dihr_top_tb.sv ----
// Self-checking bench of the hold reset generator
`timescale 1ns/10ps
module dihr_top_tb;
   // Shortened hold time, pulse width and test delay, in cycles
   localparam int unsigned HOLD = 200;
   localparam int unsigned PW = 50;
   localparam int unsigned TEST_DLY = 100;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic press_a = 1'b0;
   logic press_b = 1'b0;
   logic oe, out_val, test_mode, reset_wire;
   logic tm_seen = 1'b0;
   dihr_pkg::dihr_pins_type pins;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   int wcnt = 0;
   // Expected pulse widths in cycles
   int exp_q[$];
   // Free running 25 MHz clock
   initial forever #20 sys_clk = ~sys_clk;
   dihr_switch_model partner (.press_a(press_a), .press_b(press_b),
      .reset_line_out(out_val), .reset_line_oe(oe), .pins(pins), .reset_wire(reset_wire));
   dihr_top #(.HOLD_TIMEOUT_CYC(HOLD), .PULSE_WIDTH_CYC(PW), .TEST_DELAY_CYC(TEST_DLY)) DUT (
      .sys_clk(sys_clk), .rst(rst), .manual_input_a_n(pins.a), .manual_input_b_n(pins.b),
      .reset_line_out(out_val), .reset_line_oe(oe), .accelerated_timer_test_mode(test_mode));
   // Verdict and end of run
   task summarize;
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   // Compare of a count
   task chk_n(input string name, input int exp, input int got);
      checks++;
      if (exp != got)
      begin
         fail_count++;
         $display("BAD %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk_n
   // Compare of a single level
   task chk_b(input string name, input logic exp, input logic got);
      checks++;
      if (exp !== got)
      begin
         fail_count++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_b
   // Wait n rising edges, then step just past the edge
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick
   // Press (1) or release (0) both switches
   task drive(input logic a, input logic b);
      press_a = a;
      press_b = b;
   endtask : drive
   // Wait out any pulse, then nothing may be owed
   task settle(input logic exp_tm);
      tick(PW + 40);
      chk_n("pending pulses", 0, exp_q.size());
      chk_b("test mode seen", exp_tm, tm_seen);
      tm_seen = 1'b0;
   endtask : settle
   // Press both, in either order, and await one pulse
   task hold_pair(input logic a_first);
      drive(a_first, !a_first);
      tick(1 + $urandom % 40);
      drive(1'b1, 1'b1);
      exp_q.push_back(PW);
      tick(HOLD + PW + 20);
   endtask : hold_pair
   // Test clock on b while a is held, b ends released
   task tclk(input int n, input int half);
      drive(1'b1, 1'b0);
      tick(30);
      repeat (n)
      begin
         drive(1'b1, 1'b1);
         tick(half + $urandom % 3);
         drive(1'b1, 1'b0);
         tick(half + $urandom % 3);
      end
   endtask : tclk
   // Watcher: measures low time on the reset wire, then minds the cycle ceiling
   always @(negedge sys_clk)
   begin
      cyc = cyc + 1;
      if (reset_wire === 1'b0)
         wcnt = wcnt + 1;
      else if (wcnt != 0)
      begin
         if (exp_q.size() == 0)
            chk_n("unexpected pulse", 0, wcnt);
         else
            chk_n("pulse width", exp_q.pop_front(), wcnt);
         wcnt = 0;
      end
      if (test_mode === 1'b1)
         tm_seen = 1'b1;
      // Ceiling reached: count it and end the run
      if (cyc == 20000)
      begin
         fail_count++;
         summarize();
      end
   end
   // Main sequence
   initial
   begin
      void'($urandom(32'h458c));
      tick(8);
      rst = 1'b0;
      tick(300);
      chk_b("output released", 1'b0, oe);
      settle(1'b0);
      hold_pair(1'b1);
      tick(3 * HOLD);
      drive(1'b1, 1'b0);
      tick(20);
      drive(1'b1, 1'b1);
      exp_q.push_back(PW);
      tick(HOLD + PW + 20);
      drive(1'b0, 1'b0);
      settle(1'b0);
      hold_pair(1'b0);
      drive(1'b0, 1'b0);
      settle(1'b0);
      drive(1'b1, 1'b1);
      tick(HOLD - 20);
      drive(1'b0, 1'b1);
      tick(20);
      drive(1'b1, 1'b1);
      exp_q.push_back(PW);
      tick(HOLD - 10);
      chk_n("pulse owed", 1, exp_q.size());
      tick(PW + 30);
      drive(1'b0, 1'b0);
      settle(1'b0);
      tclk(8, 12);
      exp_q.push_back(PW);
      tick(TEST_DLY + PW + 40);
      chk_b("test mode after pulse", 1'b0, test_mode);
      drive(1'b0, 1'b0);
      settle(1'b1);
      tclk(8, 12);
      tick(20);
      drive(1'b0, 1'b0);
      settle(1'b1);
      tclk(7, 12);
      tick(900);
      drive(1'b0, 1'b0);
      settle(1'b0);
      tclk(8, 60);
      tick(300);
      drive(1'b0, 1'b0);
      settle(1'b0);
      summarize();
   end
endmodule : dihr_top_tb
